/* File: hw/ert_params.svh */
// named constants for the expert tuning register bank
`ifndef ERT_PARAMS_SVH
`define ERT_PARAMS_SVH

// register addresses on the serial control interface
`define ERT_ADDR_PLL_VCO      7'h31
`define ERT_ADDR_STARTUP      7'h32
`define ERT_ADDR_DEMOD_RSSI   7'h33
`define ERT_ADDR_W            7

// power-on values of the three registers and the charge pump, read value of unmapped addresses
`define ERT_PLL_VCO_RESET     8'h04
`define ERT_STARTUP_RESET     8'h49
`define ERT_DEMOD_RSSI_RESET  8'h02
`define ERT_ICP_RESET_UA      9'h03C
`define ERT_UNMAPPED_READ     8'h00

// reserved bits of startup_delay_control: read-only, fixed pattern
`define ERT_STARTUP_RFU_MASK  8'h18
`define ERT_STARTUP_RFU_VALUE 8'h08

// field positions
`define ERT_SWING_BIT         7
`define ERT_LONG_PD_BIT       6
`define ERT_FAST_CF_BIT       5
`define ERT_ICP_MSB           4
`define ERT_ICP_LSB           0
`define ERT_XO_MSB            7
`define ERT_XO_LSB            6
`define ERT_ASK_MID_BIT       5
`define ERT_FRAC_DIS_BIT      2
`define ERT_LOCK_MSB          1
`define ERT_LOCK_LSB          0
`define ERT_DUAL_LIM_BIT      7
`define ERT_WIDE_FM_BIT       6
`define ERT_WIDE_WIN_BIT      5
`define ERT_SHORT_TO_BIT      4
`define ERT_RSSI_TIMING_BIT   3
`define ERT_FAST_RSSI_BIT     2
`define ERT_CAP_MSB           1
`define ERT_CAP_LSB           0

// timing: clock rate and delay units as printed
`define ERT_CLK_MHZ           100
`define ERT_XO_UNIT_US        256
`define ERT_LOCK_UNIT_US      16
`define ERT_TIMER_W           17

// analog setting figures presented to the analog side
`define ERT_PD_RESET_NOM_PS   12'h834
`define ERT_PD_RESET_LONG_PS  12'hC1C
`define ERT_ICP_STEP_UA       9'h00F
`define ERT_BB_RESET_ZERO     6'h00
`define ERT_BB_RESET_MID      6'h20
`define ERT_FM_LOW_NARROW_KHZ 10'h0C8
`define ERT_FM_LOW_WIDE_KHZ   10'h000
`define ERT_FM_HIGH_NARROW_KHZ 10'h190
`define ERT_FM_HIGH_WIDE_KHZ  10'h258
`define ERT_WIN_NARROW        3'h2
`define ERT_WIN_WIDE          3'h4
`define ERT_TO_LONG_HALF      3'h7
`define ERT_TO_SHORT_HALF     3'h5
`define ERT_RSSI_B5_SLOW      2'h3
`define ERT_RSSI_B4_SLOW      2'h1
`define ERT_RSSI_B_EVEN       2'h2
`define ERT_SETTLE_TC_SLOW    3'h4
`define ERT_SETTLE_TC_FAST    3'h2
`define ERT_SETTLE_PCT_SLOW   4'h2
`define ERT_SETTLE_PCT_FAST   4'hE
`define ERT_CAP_PF_0          4'h0
`define ERT_CAP_PF_1          4'h2
`define ERT_CAP_PF_2          4'h5
`define ERT_CAP_PF_3          4'hC

`endif

/* File: hw/ert_pkg.sv */
// types shared by the expert tuning register bank
`include "ert_params.svh"

package ert_pkg;

  // serial frame states, one-hot
  typedef enum logic [3:0] {
    ERT_SPI_IDLE = 4'h1,
    ERT_SPI_CMD  = 4'h2,
    ERT_SPI_DATA = 4'h4,
    ERT_SPI_HOLD = 4'h8
  } ert_spi_state_t;

  // serial slave state
  typedef struct packed {
    logic [1:0]                 sclkSync;
    logic [1:0]                 enSync;
    logic [1:0]                 sdiSync;
    logic                       sclkPrev;
    ert_spi_state_t             state;
    logic [2:0]                 bitCnt;
    logic [7:0]                 shift;
    logic                       isRead;
    logic                       loadPending;
    logic [`ERT_ADDR_W-1:0]     addr;
    logic                       wrStrobe;
    logic [7:0]                 wrData;
    logic                       sdoOut;
    logic                       sdoOe;
  } ert_spi_regs_t;

  // delay timer state
  typedef struct packed {
    logic                       trgPrev;
    logic                       armed;
    logic                       done;
    logic [`ERT_TIMER_W-1:0]    count;
  } ert_timer_regs_t;

endpackage : ert_pkg

/* File: hw/ert_delay_timer.sv */
// one-shot delay: expires a loaded number of cycles after trigger rises
`include "ert_params.svh"
module ert_delay_timer (
  // clock and control
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     clkEn,
  // trigger level and delay length in cycles
  input  wire logic                     trigger,
  input  wire logic [`ERT_TIMER_W-1:0]  loadCount,
  // delay elapsed, held while trigger stays high
  output logic                          expired
);
  import ert_pkg::*;

  ert_timer_regs_t q;  // registered state
  ert_timer_regs_t d;  // next state

  // next state: arm on rising trigger, count down, hold done
  always_comb begin
    d = q;
    d.trgPrev = trigger;
    if (!trigger) begin
      // trigger dropped: abandon any delay
      d.armed = 1'b0;
      d.done  = 1'b0;
    end else if (!q.trgPrev) begin
      // fresh trigger: load the delay length
      d.count = loadCount;
      d.armed = 1'b1;
      d.done  = 1'b0;
    end else if (q.armed) begin
      if (q.count <= `ERT_TIMER_W'(1)) begin
        d.armed = 1'b0;
        d.done  = 1'b1;
      end else begin
        d.count = q.count - `ERT_TIMER_W'(1);
      end
    end
  end

  // state register, frozen while clkEn is low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign expired = q.done;

endmodule : ert_delay_timer

/* File: hw/ert_spi_slave.sv */
// three-wire serial slave: command byte then one data byte
`include "ert_params.svh"
module ert_spi_slave (
  // clock and control
  input  wire logic                     clk,
  input  wire logic                     resetn,
  input  wire logic                     clkEn,
  // serial pins, shared data line split in three
  input  wire logic                     spiEnable,
  input  wire logic                     spiClk,
  input  wire logic                     sdioIn,
  output logic                          sdioOut,
  output logic                          sdioOe,
  // register side
  output logic [`ERT_ADDR_W-1:0]        regAddr,
  output logic                          regWrite,
  output logic [7:0]                    regWrData,
  input  wire logic [7:0]               regRdData
);
  import ert_pkg::*;

  ert_spi_regs_t q;  // registered state
  ert_spi_regs_t d;  // next state
  logic          sclkRise;  // synced clock rising
  logic          sclkFall;  // synced clock falling

  // edges seen only on second sync stage against its delayed copy
  assign sclkRise = q.sclkSync[1] & ~q.sclkPrev;
  assign sclkFall = ~q.sclkSync[1] & q.sclkPrev;

  // frame sequencing
  always_comb begin
    d = q;
    d.sclkSync = {q.sclkSync[0], spiClk};
    d.enSync   = {q.enSync[0], spiEnable};
    d.sdiSync  = {q.sdiSync[0], sdioIn};
    d.sclkPrev = q.sclkSync[1];
    d.wrStrobe = 1'b0;
    d.loadPending = 1'b0;
    if (q.loadPending) begin
      // fetch read data once the address has settled
      d.shift = regRdData;
    end
    if (!q.enSync[1]) begin
      // interface disabled: release the data line
      d.state = ERT_SPI_IDLE;
      d.sdoOe = 1'b0;
    end else begin
      case (q.state)
        ERT_SPI_IDLE: begin
          d.state  = ERT_SPI_CMD;
          d.bitCnt = 3'h0;
        end
        ERT_SPI_CMD: begin
          if (sclkRise) begin
            d.shift  = {q.shift[6:0], q.sdiSync[1]};
            d.bitCnt = q.bitCnt + 3'h1;
            if (q.bitCnt == 3'h7) begin
              d.isRead      = q.shift[6];
              d.addr        = {q.shift[5:0], q.sdiSync[1]};
              d.loadPending = q.shift[6];
              d.state       = ERT_SPI_DATA;
            end
          end
        end
        ERT_SPI_DATA: begin
          if (q.isRead && sclkFall) begin
            // drive the next read bit, msb first
            d.sdoOut = q.shift[7];
            d.sdoOe  = 1'b1;
            d.shift  = {q.shift[6:0], 1'b0};
          end
          if (sclkRise) begin
            d.bitCnt = q.bitCnt + 3'h1;
            if (!q.isRead) begin
              d.shift = {q.shift[6:0], q.sdiSync[1]};
            end
            if (q.bitCnt == 3'h7) begin
              d.wrStrobe = ~q.isRead;
              d.wrData   = {q.shift[6:0], q.sdiSync[1]};
              d.state    = ERT_SPI_HOLD;
            end
          end
        end
        ERT_SPI_HOLD: begin
          // frame complete: wait for disable
          if (sclkFall) begin
            d.sdoOe = 1'b0;
          end
        end
        default: begin
          d.state = ERT_SPI_IDLE;
        end
      endcase
    end
  end

  // state register, frozen while clkEn is low
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q       <= '0;
      q.state <= ERT_SPI_IDLE;
    end else if (clkEn) begin
      q <= d;
    end
  end

  assign sdioOut   = q.sdoOut;
  assign sdioOe    = q.sdoOe;
  assign regAddr   = q.addr;
  assign regWrite  = q.wrStrobe;
  assign regWrData = q.wrData;

endmodule : ert_spi_slave

/* File: hw/ert_expert_regs.sv */
// expert tuning registers: serial access, field decode, start-up delays
`include "ert_params.svh"
module ert_expert_regs #(
  parameter int XO_UNIT_CYCLES   = `ERT_XO_UNIT_US * `ERT_CLK_MHZ,
  parameter int LOCK_UNIT_CYCLES = `ERT_LOCK_UNIT_US * `ERT_CLK_MHZ
) (
  // clock, reset, enable
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        clkEn,
  // serial control interface pins
  input  wire logic        spiEnable,
  input  wire logic        spiClk,
  input  wire logic        sdioIn,
  output logic             sdioOut,
  output logic             sdioOe,
  // receiver context from on-chip logic
  input  wire logic        lowBandActive,
  input  wire logic        askReceive,
  // analog status pins, asynchronous
  input  wire logic        crystalReady,
  input  wire logic        pllPhysLock,
  // start-up sequencing
  output logic             crystalStartDone,
  output logic             pllLockDone,
  // PLL settings
  output logic             vcoSwingReduce,
  output logic [11:0]      pdResetWidthPs,
  output logic [8:0]       chargePumpMicroamp,
  output logic             fractionDisable,
  // channel filter and baseband settings
  output logic             fastChanFilterSettle,
  output logic             bbResetEnable,
  output logic [5:0]       bbResetLevel,
  // demodulator settings
  output logic             dualLimiterDemod,
  output logic [9:0]       fmRangeLowKhz,
  output logic [9:0]       fmRangeHighKhz,
  output logic [2:0]       edgeWindowSamples,
  output logic [2:0]       chipTimeoutHalfChips,
  // RSSI converter and filter settings
  output logic [1:0]       rssiBit5Clocks,
  output logic [1:0]       rssiBit4Clocks,
  output logic [2:0]       rssiSettleTimeConst,
  output logic [3:0]       rssiSettlePercent,
  output logic [1:0]       rssiCapTrim,
  output logic [3:0]       rssiCapPicofarad
);
  import ert_pkg::*;

  // whole block state
  typedef struct packed {
    logic [7:0]  pllVco;        // pll_vco_tuning
    logic [7:0]  startup;       // startup_delay_control
    logic [7:0]  demodRssi;     // demod_rssi_tuning
    logic [1:0]  xoSync;        // crystal ready synchroniser
    logic [1:0]  lockSync;      // pll lock synchroniser
    logic        lowBandPrev;   // lower band edge detect
    logic [11:0] pdWidth;       // decoded outputs below
    logic [8:0]  icpUa;
    logic        bbEnable;
    logic [5:0]  bbLevel;
    logic [9:0]  fmLow;
    logic [9:0]  fmHigh;
    logic [2:0]  window;
    logic [2:0]  timeout;
    logic [1:0]  b5Clocks;
    logic [1:0]  b4Clocks;
    logic [2:0]  settleTc;
    logic [3:0]  settlePct;
    logic [3:0]  capPf;
  } ert_bank_t;

  ert_bank_t                q;            // registered state
  ert_bank_t                d;            // next state
  logic [1:0]               rstSync;      // reset release chain
  logic                     rstSyncN;     // synchronised reset
  logic [`ERT_ADDR_W-1:0]   regAddr;      // serial address
  logic                     regWrite;     // serial write pulse
  logic [7:0]               regWrData;    // serial write data
  logic [7:0]               regRdData;    // read mux result
  logic [`ERT_TIMER_W-1:0]  xoLoad;       // crystal delay in cycles
  logic [`ERT_TIMER_W-1:0]  lockLoad;     // lock delay in cycles
  logic [1:0]               xoCode;       // crystal delay code
  logic [1:0]               lockCode;     // lock delay code

  // reset asserts at once, releases through two flops
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rstSync <= 2'h0;
    end else begin
      rstSync <= {rstSync[0], 1'b1};
    end
  end
  assign rstSyncN = rstSync[1];

  // serial framing of register accesses
  ert_spi_slave uSpi (
    .clk       (mclk),
    .resetn    (rstSyncN),
    .clkEn     (clkEn),
    .spiEnable (spiEnable),
    .spiClk    (spiClk),
    .sdioIn    (sdioIn),
    .sdioOut   (sdioOut),
    .sdioOe    (sdioOe),
    .regAddr   (regAddr),
    .regWrite  (regWrite),
    .regWrData (regWrData),
    .regRdData (regRdData)
  );

  // read mux, unmapped addresses read zero
  always_comb begin
    case (regAddr)
      `ERT_ADDR_PLL_VCO:    regRdData = q.pllVco;
      `ERT_ADDR_STARTUP:    regRdData = q.startup;
      `ERT_ADDR_DEMOD_RSSI: regRdData = q.demodRssi;
      default:              regRdData = `ERT_UNMAPPED_READ;
    endcase
  end

  // delay lengths: code plus one times the unit
  assign xoCode   = q.startup[`ERT_XO_MSB:`ERT_XO_LSB];
  assign lockCode = q.startup[`ERT_LOCK_MSB:`ERT_LOCK_LSB];
  assign xoLoad   = `ERT_TIMER_W'(({1'b0, xoCode} + 3'h1) * XO_UNIT_CYCLES);
  assign lockLoad = `ERT_TIMER_W'(({1'b0, lockCode} + 3'h1) * LOCK_UNIT_CYCLES);

  // crystal start-up delay after crystal ready
  ert_delay_timer uXoTimer (
    .clk       (mclk),
    .resetn    (rstSyncN),
    .clkEn     (clkEn),
    .trigger   (q.xoSync[1]),
    .loadCount (xoLoad),
    .expired   (crystalStartDone)
  );

  // extra delay after physical PLL lock
  ert_delay_timer uLockTimer (
    .clk       (mclk),
    .resetn    (rstSyncN),
    .clkEn     (clkEn),
    .trigger   (q.lockSync[1]),
    .loadCount (lockLoad),
    .expired   (pllLockDone)
  );

  // register writes, automatic swing bit, decode of settings
  always_comb begin
    d = q;
    d.xoSync      = {q.xoSync[0], crystalReady};
    d.lockSync    = {q.lockSync[0], pllPhysLock};
    d.lowBandPrev = lowBandActive;

    // host writes
    if (regWrite) begin
      case (regAddr)
        `ERT_ADDR_PLL_VCO: begin
          d.pllVco = regWrData;
        end
        `ERT_ADDR_STARTUP: begin
          // reserved bits keep their fixed pattern
          d.startup = (regWrData & ~`ERT_STARTUP_RFU_MASK)
                    | `ERT_STARTUP_RFU_VALUE;
        end
        `ERT_ADDR_DEMOD_RSSI: begin
          d.demodRssi = regWrData;
        end
        default: begin
          // unmapped write ignored
        end
      endcase
    end

    // entering the lower band sets swing reduce, winning over a write
    if (lowBandActive && !q.lowBandPrev) begin
      d.pllVco[`ERT_SWING_BIT] = 1'b1;
    end

    // phase detector reset width
    d.pdWidth = q.pllVco[`ERT_LONG_PD_BIT] ? `ERT_PD_RESET_LONG_PS
                                           : `ERT_PD_RESET_NOM_PS;
    // charge pump current in microamps
    d.icpUa = 9'(q.pllVco[`ERT_ICP_MSB:`ERT_ICP_LSB]) * `ERT_ICP_STEP_UA;

    // baseband reset only in ASK reception
    d.bbEnable = askReceive;
    d.bbLevel  = q.startup[`ERT_ASK_MID_BIT] ? `ERT_BB_RESET_MID
                                             : `ERT_BB_RESET_ZERO;

    // FM demodulator input range
    d.fmLow  = q.demodRssi[`ERT_WIDE_FM_BIT] ? `ERT_FM_LOW_WIDE_KHZ
                                             : `ERT_FM_LOW_NARROW_KHZ;
    d.fmHigh = q.demodRssi[`ERT_WIDE_FM_BIT] ? `ERT_FM_HIGH_WIDE_KHZ
                                             : `ERT_FM_HIGH_NARROW_KHZ;

    // edge amplitude window
    d.window = q.demodRssi[`ERT_WIDE_WIN_BIT] ? `ERT_WIN_WIDE
                                              : `ERT_WIN_NARROW;
    // chip timeout in half chip periods
    d.timeout = q.demodRssi[`ERT_SHORT_TO_BIT] ? `ERT_TO_SHORT_HALF
                                               : `ERT_TO_LONG_HALF;

    // RSSI converter top-bit timing
    if (q.demodRssi[`ERT_RSSI_TIMING_BIT]) begin
      d.b5Clocks = `ERT_RSSI_B_EVEN;
      d.b4Clocks = `ERT_RSSI_B_EVEN;
    end else begin
      d.b5Clocks = `ERT_RSSI_B5_SLOW;
      d.b4Clocks = `ERT_RSSI_B4_SLOW;
    end

    // RSSI filter settling
    if (q.demodRssi[`ERT_FAST_RSSI_BIT]) begin
      d.settleTc  = `ERT_SETTLE_TC_FAST;
      d.settlePct = `ERT_SETTLE_PCT_FAST;
    end else begin
      d.settleTc  = `ERT_SETTLE_TC_SLOW;
      d.settlePct = `ERT_SETTLE_PCT_SLOW;
    end

    // RSSI capacitor selected by trim code
    case (q.demodRssi[`ERT_CAP_MSB:`ERT_CAP_LSB])
      2'h0:    d.capPf = `ERT_CAP_PF_0;
      2'h1:    d.capPf = `ERT_CAP_PF_1;
      2'h2:    d.capPf = `ERT_CAP_PF_2;
      2'h3:    d.capPf = `ERT_CAP_PF_3;
      default: d.capPf = `ERT_CAP_PF_0;
    endcase
  end

  // state register; power-on values, frozen while clkEn is low
  always_ff @(posedge mclk or negedge rstSyncN) begin
    if (!rstSyncN) begin
      q           <= '0;
      q.pllVco    <= `ERT_PLL_VCO_RESET;
      q.startup   <= `ERT_STARTUP_RESET;
      q.demodRssi <= `ERT_DEMOD_RSSI_RESET;
      q.pdWidth   <= `ERT_PD_RESET_NOM_PS;
      q.icpUa     <= `ERT_ICP_RESET_UA;
      q.fmLow     <= `ERT_FM_LOW_NARROW_KHZ;
      q.fmHigh    <= `ERT_FM_HIGH_NARROW_KHZ;
      q.window    <= `ERT_WIN_NARROW;
      q.timeout   <= `ERT_TO_LONG_HALF;
      q.b5Clocks  <= `ERT_RSSI_B5_SLOW;
      q.b4Clocks  <= `ERT_RSSI_B4_SLOW;
      q.settleTc  <= `ERT_SETTLE_TC_SLOW;
      q.settlePct <= `ERT_SETTLE_PCT_SLOW;
      q.capPf     <= `ERT_CAP_PF_2;
    end else if (clkEn) begin
      q <= d;
    end
  end

  // single-bit settings and the capacitor trim code straight from register bits
  assign vcoSwingReduce       = q.pllVco[`ERT_SWING_BIT];
  assign fastChanFilterSettle = q.pllVco[`ERT_FAST_CF_BIT];
  assign fractionDisable      = q.startup[`ERT_FRAC_DIS_BIT];
  assign dualLimiterDemod     = q.demodRssi[`ERT_DUAL_LIM_BIT];
  assign rssiCapTrim          = q.demodRssi[`ERT_CAP_MSB:`ERT_CAP_LSB];

  // decoded settings from their flops
  assign pdResetWidthPs       = q.pdWidth;
  assign chargePumpMicroamp   = q.icpUa;
  assign bbResetEnable        = q.bbEnable;
  assign bbResetLevel         = q.bbLevel;
  assign fmRangeLowKhz        = q.fmLow;
  assign fmRangeHighKhz       = q.fmHigh;
  assign edgeWindowSamples    = q.window;
  assign chipTimeoutHalfChips = q.timeout;
  assign rssiBit5Clocks       = q.b5Clocks;
  assign rssiBit4Clocks       = q.b4Clocks;
  assign rssiSettleTimeConst  = q.settleTc;
  assign rssiSettlePercent    = q.settlePct;
  assign rssiCapPicofarad     = q.capPf;

endmodule : ert_expert_regs

/* File: verif/ert_host_model.sv */
// host controller model on the serial control interface
module ert_host_model (
  // clock
  input  wire logic mclk,
  // serial pins
  output logic      spiEnable,
  output logic      spiClk,
  output logic      sdioIn,
  input  wire logic sdioOut,
  input  wire logic sdioOe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic hostBit; // level the host puts on the line
  // shared line: device wins while it drives
  assign sdioIn = sdioOe ? sdioOut : hostBit;
  initial begin
    spiEnable = 1'b0;
    spiClk    = 1'b0;
    hostBit   = 1'b0;
  end
  // wait n edges, then step just past the edge
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : cyc
  // one frame: command byte then data byte, msb first, slow phases
  task automatic xfer(input logic rd, input logic [6:0] a, input logic [7:0] wd,
                      output logic [7:0] rdat);
    logic [15:0] w;
    w = {rd, a, wd};
    spiEnable = 1'b1;
    cyc(5);
    for (int i = 15; i >= 0; i--) begin
      hostBit = w[i];
      cyc(5);
      spiClk = 1'b1;
      if (i < 8) rdat[i] = sdioIn;
      cyc(5);
      spiClk = 1'b0;
    end
    cyc(5);
    spiEnable = 1'b0;
    hostBit = ~hostBit; // released line shows no stale bit
    cyc(6);
  endtask : xfer
endmodule : ert_host_model

/* File: verif/ert_expert_regs_asserts.sv */
// port checks for the expert tuning register bank
module ert_expert_regs_asserts (
  // clock and reset
  input wire logic       mclk, resetn,
  // inputs watched
  input wire logic       spiEnable, lowBandActive, askReceive, crystalReady, pllPhysLock,
  // outputs watched
  input wire logic       sdioOe, crystalStartDone, pllLockDone, vcoSwingReduce, bbResetEnable,
  input wire logic [9:0] fmRangeLowKhz, fmRangeHighKhz,
  input wire logic [2:0] rssiSettleTimeConst,
  input wire logic [3:0] rssiSettlePercent, rssiCapPicofarad,
  input wire logic [1:0] rssiCapTrim
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (!resetn);
  // capacitor per trim code
  function automatic logic [3:0] capOf(input logic [1:0] c);
    return c[1] ? (c[0] ? 4'hC : 4'h5) : (c[0] ? 4'h2 : 4'h0);
  endfunction : capOf
  chk_swing_auto: assert property ($rose(lowBandActive) |-> ##[1:3] vcoSwingReduce)
    else $error("swing reduce not set");
  chk_bb_follow: assert property (bbResetEnable |-> $past(askReceive))
    else $error("baseband reset outside ask");
  chk_fm_range: assert property (fmRangeLowKhz == 10'h000 ? fmRangeHighKhz == 10'h258
    : fmRangeLowKhz == 10'h0C8 && fmRangeHighKhz == 10'h190) else $error("fm range bad");
  chk_settle_pair: assert property (rssiSettleTimeConst == 3'h4 ? rssiSettlePercent == 4'h2
    : rssiSettleTimeConst == 3'h2 && rssiSettlePercent == 4'hE) else $error("settle bad");
  chk_cap_map: assert property ($stable(rssiCapTrim) |-> rssiCapPicofarad == capOf(rssiCapTrim))
    else $error("capacitor map bad");
  chk_xo_clear: assert property (!crystalReady [*6] |-> !crystalStartDone)
    else $error("crystal done without ready");
  chk_lock_clear: assert property (!pllPhysLock [*6] |-> !pllLockDone)
    else $error("lock done without lock");
  chk_sdio_release: assert property ($fell(spiEnable) |-> ##[1:6] !sdioOe)
    else $error("data line still driven");
  // main scenarios reached
  cover property ($rose(sdioOe));
  cover property ($rose(crystalStartDone));
  cover property ($rose(pllLockDone));
endmodule : ert_expert_regs_asserts

/* File: verif/tb_ert_expert_regs.sv */
// self-checking bench for the expert tuning register bank
`include "ert_params.svh"
module tb_ert_expert_regs;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int XO = 20; // shortened crystal delay unit
  localparam int LK = 5;  // shortened lock delay unit
  logic mclk, resetn, clkEn, lowBandActive, askReceive;
  logic crystalReady, pllPhysLock, spiEnable, spiClk, sdioIn, sdioOut, sdioOe;
  logic crystalStartDone, pllLockDone, vcoSwingReduce, fractionDisable, fastChanFilterSettle;
  logic bbResetEnable, dualLimiterDemod;
  logic [11:0] pdResetWidthPs;
  logic [8:0]  chargePumpMicroamp;
  logic [5:0]  bbResetLevel;
  logic [9:0]  fmRangeLowKhz, fmRangeHighKhz;
  logic [2:0]  edgeWindowSamples, chipTimeoutHalfChips, rssiSettleTimeConst;
  logic [1:0]  rssiBit5Clocks, rssiBit4Clocks, rssiCapTrim;
  logic [3:0]  rssiSettlePercent, rssiCapPicofarad;
  logic [7:0]  rd;
  int          errTotal = 0, totalChecks = 0;
  always #5 mclk = ~mclk;
  ert_expert_regs #(.XO_UNIT_CYCLES(XO), .LOCK_UNIT_CYCLES(LK)) i_dut (
    .mclk, .resetn, .clkEn, .spiEnable, .spiClk, .sdioIn, .sdioOut, .sdioOe, .lowBandActive,
    .askReceive, .crystalReady, .pllPhysLock, .crystalStartDone, .pllLockDone, .vcoSwingReduce,
    .pdResetWidthPs, .chargePumpMicroamp, .fractionDisable, .fastChanFilterSettle,
    .bbResetEnable, .bbResetLevel, .dualLimiterDemod, .fmRangeLowKhz, .fmRangeHighKhz,
    .edgeWindowSamples, .chipTimeoutHalfChips, .rssiBit5Clocks, .rssiBit4Clocks,
    .rssiSettleTimeConst, .rssiSettlePercent, .rssiCapTrim, .rssiCapPicofarad);
  ert_host_model i_host (.mclk, .spiEnable, .spiClk, .sdioIn, .sdioOut, .sdioOe);
  // compare one value
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    totalChecks++;
    if (g !== e) begin
      errTotal++;
      $display("ERROR %s expected %0h seen %0h", n, e, g);
    end
  endtask : chk
  // register write and checked read
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_host.xfer(1'b0, a, d, rd);
  endtask : wr
  task automatic rdReg(input logic [6:0] a, input logic [7:0] e);
    i_host.xfer(1'b1, a, 8'h00, rd);
    chk("readback", {4'h0, e}, {4'h0, rd});
  endtask : rdReg
  task automatic testReset;
    rdReg(`ERT_ADDR_PLL_VCO, 8'h04);
    rdReg(`ERT_ADDR_STARTUP, 8'h49);
    rdReg(`ERT_ADDR_DEMOD_RSSI, 8'h02);
    chk("pd", 12'h834, pdResetWidthPs);
    chk("icp", 12'h03C, {3'h0, chargePumpMicroamp});
    chk("bbLevel", 12'h0, {6'h0, bbResetLevel});
    $display("reset test done");
  endtask : testReset
  task automatic testPll;
    wr(`ERT_ADDR_PLL_VCO, 8'h7F);
    rdReg(`ERT_ADDR_PLL_VCO, 8'h7F);
    chk("pd", 12'hC1C, pdResetWidthPs);
    chk("icp", 12'h1D1, {3'h0, chargePumpMicroamp});
    chk("cfSettle", 12'h1, {11'h0, fastChanFilterSettle});
    lowBandActive = 1'b1;
    i_host.cyc(3);
    rdReg(`ERT_ADDR_PLL_VCO, 8'hFF);
    chk("swing", 12'h1, {11'h0, vcoSwingReduce});
    lowBandActive = 1'b0;
    wr(`ERT_ADDR_PLL_VCO, 8'h04); // host restores power-on value
    $display("pll test done");
  endtask : testPll
  task automatic testStartup;
    wr(`ERT_ADDR_STARTUP, 8'hE7);
    rdReg(`ERT_ADDR_STARTUP, 8'hEF);
    chk("fracDis", 12'h1, {11'h0, fractionDisable});
    chk("bbLevel", 12'h020, {6'h0, bbResetLevel});
    clkEn = 1'b0;
    askReceive = 1'b1;
    i_host.cyc(3);
    chk("frozen", 12'h0, {11'h0, bbResetEnable});
    clkEn = 1'b1;
    i_host.cyc(3);
    chk("bbEnable", 12'h1, {11'h0, bbResetEnable});
    askReceive = 1'b0;
    wr(7'h34, 8'hFF);
    rdReg(7'h34, 8'h00);
    $display("startup test done");
  endtask : testStartup
  task automatic testDelays;
    for (int k = 0; k < 4; k++) begin
      wr(`ERT_ADDR_STARTUP, {k[1:0], 4'h0, k[1:0]});
      crystalReady = 1'b1;
      pllPhysLock = 1'b1;
      i_host.cyc((k + 1) * LK - 2);
      chk("lockEarly", 12'h0, {11'h0, pllLockDone});
      i_host.cyc(10);
      chk("lockDone", 12'h1, {11'h0, pllLockDone});
      i_host.cyc((k + 1) * (XO - LK) - 10);
      chk("xoEarly", 12'h0, {11'h0, crystalStartDone});
      i_host.cyc(10);
      chk("xoDone", 12'h1, {11'h0, crystalStartDone});
      crystalReady = 1'b0;
      pllPhysLock = 1'b0;
      i_host.cyc(8);
    end
    $display("delay test done");
  endtask : testDelays
  task automatic testDemod(input logic [7:0] v);
    logic [11:0] capTbl [4] = '{12'h0, 12'h2, 12'h5, 12'hC};
    wr(`ERT_ADDR_DEMOD_RSSI, v);
    rdReg(`ERT_ADDR_DEMOD_RSSI, v);
    chk("dual", {11'h0, v[7]}, {11'h0, dualLimiterDemod});
    chk("fmLow", v[6] ? 12'h0 : 12'h0C8, {2'h0, fmRangeLowKhz});
    chk("fmHigh", v[6] ? 12'h258 : 12'h190, {2'h0, fmRangeHighKhz});
    chk("bit5", v[3] ? 12'h2 : 12'h3, {10'h0, rssiBit5Clocks});
    chk("pct", v[2] ? 12'hE : 12'h2, {8'h0, rssiSettlePercent});
    chk("trim", {10'h0, v[1:0]}, {10'h0, rssiCapTrim});
    chk("window", v[5] ? 12'h4 : 12'h2, {9'h0, edgeWindowSamples});
    chk("timeout", v[4] ? 12'h5 : 12'h7, {9'h0, chipTimeoutHalfChips});
    chk("bit4", v[3] ? 12'h2 : 12'h1, {10'h0, rssiBit4Clocks});
    chk("settle", v[2] ? 12'h2 : 12'h4, {9'h0, rssiSettleTimeConst});
    chk("cap", capTbl[v[1:0]], {8'h0, rssiCapPicofarad});
    $display("demod test done");
  endtask : testDemod
  // verdict and end of run
  task automatic results;
    $display("checks %0d errors %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : results
  initial begin
    {mclk, resetn, lowBandActive, askReceive, crystalReady, pllPhysLock} = 6'h00;
    clkEn = 1'b1;
    i_host.cyc(3);
    resetn = 1'b1;
    i_host.cyc(4);
    testReset();
    testPll();
    testStartup();
    testDelays();
    testDemod(8'hA5);
    testDemod(8'h5A);
    testDemod(8'h03);
    testDemod(8'h00);
    resetn = 1'b0;
    i_host.cyc(2);
    resetn = 1'b1;
    i_host.cyc(4);
    testReset();
    results();
  end
  initial begin
    #500000;
    errTotal++;
    results();
  end
endmodule : tb_ert_expert_regs
bind ert_expert_regs ert_expert_regs_asserts i_chk (.mclk, .resetn, .spiEnable, .lowBandActive,
  .askReceive, .crystalReady, .pllPhysLock, .sdioOe, .crystalStartDone, .pllLockDone,
  .vcoSwingReduce, .bbResetEnable, .fmRangeLowKhz, .fmRangeHighKhz, .rssiSettleTimeConst,
  .rssiSettlePercent, .rssiCapPicofarad, .rssiCapTrim);
